// >>> shared/ecg_pkg.sv
// Purpose: Shared constants and types for the echo group control and tone event queue block.
// Assumes: Byte-wide registers on a plain address/strobe port, one 125 MHz clock.
// Notes:   Addresses are byte offsets on the register port, not word indices.
`default_nettype none

package ecg_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;

  // Groups of two cancellers; channel 2g is canceller A and 2g+1 is canceller B.
  localparam int unsigned GROUPS = 16;
  localparam int unsigned CHANS  = 32;
  localparam int unsigned CHAN_W = 5;
  localparam int unsigned GRP_W  = 4;

  // Register map.
  localparam logic [ADDR_W-1:0] GRP_CTRL_BASE = 11'h400;
  localparam logic [ADDR_W-1:0] GRP_CTRL_LAST = 11'h40F;
  localparam logic [ADDR_W-1:0] QUEUE_ADDR    = 11'h410;
  localparam logic [ADDR_W-1:0] TEST_ADDR     = 11'h411;
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 11'h412;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 11'h413;

  // Group control byte fields.
  localparam int unsigned CTRL_BITS  = 5;
  localparam int unsigned POWER_BIT  = 0;
  localparam int unsigned LAW_BIT    = 1;
  localparam int unsigned FORMAT_BIT = 2;
  localparam int unsigned MASK_A_BIT = 3;
  localparam int unsigned MASK_B_BIT = 4;

  // Tone event queue register fields.
  localparam int unsigned Q_PEND_BIT = 7;

  // Test register field.
  localparam int unsigned TEST_IRQ_BIT = 0;

  // Interrupt status and mask fields.
  localparam int unsigned STAT_W        = 3;
  localparam int unsigned STAT_EV_BIT   = 0;
  localparam int unsigned STAT_INIT_BIT = 1;
  localparam int unsigned STAT_FULL_BIT = 2;

  // Reset values.
  localparam logic [DATA_W-1:0] CTRL_RST  = 8'h00;
  localparam logic [DATA_W-1:0] QUEUE_RST = 8'h00;
  localparam logic [DATA_W-1:0] TEST_RST  = 8'h00;
  localparam logic [DATA_W-1:0] MASK_RST  = 8'h00;

  // Whole frames an initialization must span, and the queue depth.
  localparam int unsigned INIT_FRAMES = 2;
  localparam int unsigned QUEUE_DEPTH = 32;

  // Per-group power sequencing.
  typedef enum logic [2:0]
  {
    ST_DOWN = 3'b001,
    ST_INIT = 3'b010,
    ST_RUN  = 3'b100
  } ecg_grp_state_t;

endpackage : ecg_pkg

`default_nettype wire

// >>> rtl/ecg_queue.sv
// Purpose: First-in first-out store of channel numbers for tone events.
// Assumes: Same clock as the writer and reader; flip-flop storage.
// Notes:   push_ready_o drops when full, so the producer must hold its entry.
`timescale 1ns/1ps
`default_nettype none

module ecg_queue
(
  input  wire logic                       mclk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       push_valid_i,
  output logic                            push_ready_o,
  input  wire logic [ecg_pkg::CHAN_W-1:0] push_data_i,
  output logic                            pop_valid_o,
  input  wire logic                       pop_ready_i,
  output logic      [ecg_pkg::CHAN_W-1:0] pop_data_o
);

  localparam int unsigned PTR_W = $clog2(ecg_pkg::QUEUE_DEPTH);

  logic [ecg_pkg::CHAN_W-1:0] mem_q [ecg_pkg::QUEUE_DEPTH];
  logic [ecg_pkg::CHAN_W-1:0] mem_d [ecg_pkg::QUEUE_DEPTH];
  logic [PTR_W-1:0]           wptr_q;
  logic [PTR_W-1:0]           wptr_d;
  logic [PTR_W-1:0]           rptr_q;
  logic [PTR_W-1:0]           rptr_d;
  logic [PTR_W:0]             cnt_q;
  logic [PTR_W:0]             cnt_d;
  logic                       push;
  logic                       pop;

  // Full and empty come straight from the occupancy count.
  assign push_ready_o = (cnt_q != (PTR_W+1)'(ecg_pkg::QUEUE_DEPTH));
  assign pop_valid_o  = (cnt_q != '0);
  assign pop_data_o   = mem_q[rptr_q];
  assign push         = push_valid_i && push_ready_o;
  assign pop          = pop_valid_o && pop_ready_i;

  // Pointers wrap naturally since the depth is a power of two.
  always_comb
  begin
    mem_d  = mem_q;
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    cnt_d  = cnt_q;
    if (push)
    begin
      mem_d[wptr_q] = push_data_i;
      wptr_d        = wptr_q + 1'b1;
    end
    if (pop)
    begin
      rptr_d = rptr_q + 1'b1;
    end
    if (push && !pop)
    begin
      cnt_d = cnt_q + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Storage keeps no reset; only pointers and count need a defined value.
  always_ff @(posedge mclk_i)
  begin
    mem_q <= mem_d;
    if (!rstn_i)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end
    else
    begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q  <= cnt_d;
    end
  end

endmodule // ecg_queue

`default_nettype wire

// >>> rtl/ecg_top.sv
// Purpose: Per-group control of the echo canceller groups and the tone event queue register.
// Assumes: Single 125 MHz clock; frame_i is an asynchronous frame-start pin;
//          tone_det_i comes from the tone detectors on the same clock.
// Notes:   Registers sit at their byte offsets on a plain strobe port with read data
//          valid one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none

module ecg_top
(
  input  wire logic                        mclk_i,
  input  wire logic                        rstn_i,
  input  wire logic [ecg_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [ecg_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [ecg_pkg::DATA_W-1:0]  rdata_o,
  output logic                             irq_o,
  input  wire logic                        frame_i,
  input  wire logic [ecg_pkg::CHANS-1:0]   tone_det_i,
  input  wire logic                        rin_valid_i,
  input  wire logic [ecg_pkg::CHAN_W-1:0]  rin_chan_i,
  input  wire logic [ecg_pkg::DATA_W-1:0]  rin_data_i,
  input  wire logic [ecg_pkg::DATA_W-1:0]  ec_data_i,
  output logic                             rout_valid_o,
  output logic      [ecg_pkg::DATA_W-1:0]  rout_data_o,
  output logic      [ecg_pkg::GROUPS-1:0]  grp_active_o,
  output logic      [ecg_pkg::GROUPS-1:0]  grp_init_o,
  output logic      [ecg_pkg::GROUPS-1:0]  grp_g711_o,
  output logic      [ecg_pkg::GROUPS-1:0]  grp_alaw_o
);

  localparam int unsigned GN = ecg_pkg::GROUPS;
  localparam int unsigned CN = ecg_pkg::CHANS;

  // Register bank state.
  logic [ecg_pkg::CTRL_BITS-1:0] ctrl_q [GN];
  logic [ecg_pkg::CTRL_BITS-1:0] ctrl_d [GN];
  logic                          test_q;
  logic                          test_d;
  logic [ecg_pkg::STAT_W-1:0]    stat_q;
  logic [ecg_pkg::STAT_W-1:0]    stat_d;
  logic [ecg_pkg::STAT_W-1:0]    mask_q;
  logic [ecg_pkg::STAT_W-1:0]    mask_d;
  logic [ecg_pkg::DATA_W-1:0]    rdata_q;
  logic [ecg_pkg::DATA_W-1:0]    rdata_d;

  // Frame pin synchroniser and filtered level.
  logic [2:0]                    fr_q;
  logic                          fr_lvl_q;
  logic                          fr_lvl_d;
  logic                          frame_tick;

  // Tone event capture.
  logic [CN-1:0]                 tone_prev_q;
  logic [CN-1:0]                 pend_q;
  logic [CN-1:0]                 pend_d;
  logic [CN-1:0]                 new_ev;
  logic [CN-1:0]                 test_ev;
  logic [ecg_pkg::CHAN_W-1:0]    sel_chan;

  // Receive path.
  logic                          rout_valid_q;
  logic [ecg_pkg::DATA_W-1:0]    rout_data_q;

  // Queue handshake.
  logic                          push_valid;
  logic                          push_ready;
  logic                          pop_valid;
  logic                          pop_ready;
  logic [ecg_pkg::CHAN_W-1:0]    pop_data;

  // Group sequencing.
  ecg_pkg::ecg_grp_state_t       gst_q [GN];
  logic [GN-1:0]                 init_done;

  // Decoded accesses.
  logic                          ctrl_hit;
  logic [ecg_pkg::GRP_W-1:0]     ctrl_idx;
  logic                          queue_rd;

  assign ctrl_hit = (addr_i >= ecg_pkg::GRP_CTRL_BASE) && (addr_i <= ecg_pkg::GRP_CTRL_LAST);
  assign ctrl_idx = addr_i[ecg_pkg::GRP_W-1:0];
  assign queue_rd = rd_i && (addr_i == ecg_pkg::QUEUE_ADDR);

  // A read of the queue register removes the entry it returns.
  assign pop_ready = queue_rd;

  // Frame pin passes three flops; a new level is taken only once the second and third agree.
  always_comb
  begin
    fr_lvl_d = fr_lvl_q;
    if (fr_q[1] == fr_q[2])
    begin
      fr_lvl_d = fr_q[2];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      fr_q     <= 3'h0;
      fr_lvl_q <= 1'b0;
    end
    else
    begin
      fr_q     <= {fr_q[1:0], frame_i};
      fr_lvl_q <= fr_lvl_d;
    end
  end

  assign frame_tick = fr_lvl_d && !fr_lvl_q;

  // Register writes: group control, test and mask bytes, and write-one-to-clear status.
  always_comb
  begin
    ctrl_d = ctrl_q;
    test_d = test_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr_i && ctrl_hit)
    begin
      ctrl_d[ctrl_idx] = wdata_i[ecg_pkg::CTRL_BITS-1:0];
    end
    if (wr_i && (addr_i == ecg_pkg::TEST_ADDR))
    begin
      test_d = wdata_i[ecg_pkg::TEST_IRQ_BIT];
    end
    if (wr_i && (addr_i == ecg_pkg::IRQ_MASK_ADDR))
    begin
      mask_d = wdata_i[ecg_pkg::STAT_W-1:0];
    end
    if (wr_i && (addr_i == ecg_pkg::IRQ_STAT_ADDR))
    begin
      stat_d = stat_q & ~wdata_i[ecg_pkg::STAT_W-1:0];
    end
    // Hardware sets are applied last so an event never loses to a clear in the same cycle.
    if (push_valid && push_ready)
    begin
      stat_d[ecg_pkg::STAT_EV_BIT] = 1'b1;
    end
    if (|init_done)
    begin
      stat_d[ecg_pkg::STAT_INIT_BIT] = 1'b1;
    end
    if (push_valid && !push_ready)
    begin
      stat_d[ecg_pkg::STAT_FULL_BIT] = 1'b1;
    end
  end

  // Read data mux; unmapped addresses read as zero.
  always_comb
  begin
    rdata_d = 8'h00;
    if (rd_i && ctrl_hit)
    begin
      rdata_d[ecg_pkg::CTRL_BITS-1:0] = ctrl_q[ctrl_idx];
    end
    else if (queue_rd)
    begin
      // Bits six and five stay zero from the default above.
      rdata_d[ecg_pkg::Q_PEND_BIT]     = pop_valid;
      rdata_d[ecg_pkg::CHAN_W-1:0]     = pop_valid ? pop_data : 5'h00;
    end
    else if (rd_i && (addr_i == ecg_pkg::TEST_ADDR))
    begin
      rdata_d[ecg_pkg::TEST_IRQ_BIT]   = test_q;
    end
    else if (rd_i && (addr_i == ecg_pkg::IRQ_STAT_ADDR))
    begin
      rdata_d[ecg_pkg::STAT_W-1:0]     = stat_q;
    end
    else if (rd_i && (addr_i == ecg_pkg::IRQ_MASK_ADDR))
    begin
      rdata_d[ecg_pkg::STAT_W-1:0]     = mask_q;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      for (int g = 0; g < GN; g++)
      begin
        ctrl_q[g] <= ecg_pkg::CTRL_RST[ecg_pkg::CTRL_BITS-1:0];
      end
      test_q  <= ecg_pkg::TEST_RST[ecg_pkg::TEST_IRQ_BIT];
      mask_q  <= ecg_pkg::MASK_RST[ecg_pkg::STAT_W-1:0];
      stat_q  <= '0;
      rdata_q <= ecg_pkg::QUEUE_RST;
    end
    else
    begin
      ctrl_q  <= ctrl_d;
      test_q  <= test_d;
      mask_q  <= mask_d;
      stat_q  <= stat_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
  assign irq_o   = |(stat_q & mask_q);

  // Per-group power sequencing and the per-channel event sources of that group.
  for (genvar g = 0; g < GN; g++)
  begin : g_grp
    ecg_pkg::ecg_grp_state_t gst_d;
    logic [1:0]              fcnt_q;
    logic [1:0]              fcnt_d;
    logic                    pwr;

    assign pwr = ctrl_q[g][ecg_pkg::POWER_BIT];

    // The first tick after the rise may end a partial frame, so one extra tick is awaited.
    always_comb
    begin
      gst_d  = gst_q[g];
      fcnt_d = fcnt_q;
      unique case (gst_q[g])
        ecg_pkg::ST_DOWN:
        begin
          fcnt_d = 2'h0;
          if (pwr)
          begin
            gst_d = ecg_pkg::ST_INIT;
          end
        end
        ecg_pkg::ST_INIT:
        begin
          if (!pwr)
          begin
            gst_d = ecg_pkg::ST_DOWN;
          end
          else if (frame_tick && (fcnt_q == 2'(ecg_pkg::INIT_FRAMES)))
          begin
            gst_d = ecg_pkg::ST_RUN;
          end
          else if (frame_tick)
          begin
            fcnt_d = fcnt_q + 2'h1;
          end
        end
        ecg_pkg::ST_RUN:
        begin
          if (!pwr)
          begin
            gst_d = ecg_pkg::ST_DOWN;
          end
        end
        default:
        begin
          gst_d = ecg_pkg::ST_DOWN;
        end
      endcase
    end

    always_ff @(posedge mclk_i)
    begin
      if (!rstn_i)
      begin
        gst_q[g] <= ecg_pkg::ST_DOWN;
        fcnt_q   <= 2'h0;
      end
      else
      begin
        gst_q[g] <= gst_d;
        fcnt_q   <= fcnt_d;
      end
    end

    assign init_done[g]    = (gst_q[g] == ecg_pkg::ST_INIT) && (gst_d == ecg_pkg::ST_RUN);
    // Channel state and filter coefficients are held cleared while this is high.
    assign grp_init_o[g]   = (gst_q[g] == ecg_pkg::ST_INIT);
    assign grp_active_o[g] = (gst_q[g] == ecg_pkg::ST_RUN);
    assign grp_g711_o[g]   = ctrl_q[g][ecg_pkg::FORMAT_BIT];
    assign grp_alaw_o[g]   = ctrl_q[g][ecg_pkg::FORMAT_BIT]
                             && ctrl_q[g][ecg_pkg::LAW_BIT];

    // Detector changes count only in running groups with their channel unmasked.
    assign new_ev[2*g]   = (tone_det_i[2*g] ^ tone_prev_q[2*g]) && grp_active_o[g]
                           && !ctrl_q[g][ecg_pkg::MASK_A_BIT];
    assign new_ev[2*g+1] = (tone_det_i[2*g+1] ^ tone_prev_q[2*g+1]) && grp_active_o[g]
                           && !ctrl_q[g][ecg_pkg::MASK_B_BIT];
    // In test mode a change of a mask bit stands in for a detector change.
    assign test_ev[2*g]   = test_q && (ctrl_d[g][ecg_pkg::MASK_A_BIT]
                            != ctrl_q[g][ecg_pkg::MASK_A_BIT]);
    assign test_ev[2*g+1] = test_q && (ctrl_d[g][ecg_pkg::MASK_B_BIT]
                            != ctrl_q[g][ecg_pkg::MASK_B_BIT]);
  end

  // Pick the lowest pending channel; a channel waits here while the queue is full.
  always_comb
  begin
    sel_chan = 5'h00;
    for (int c = CN - 1; c >= 0; c--)
    begin
      if (pend_q[c])
      begin
        sel_chan = ecg_pkg::CHAN_W'(c);
      end
    end
  end

  assign push_valid = |pend_q;

  // A fresh event on the channel being pushed re-arms it rather than being lost.
  always_comb
  begin
    pend_d = pend_q;
    if (push_valid && push_ready)
    begin
      pend_d[sel_chan] = 1'b0;
    end
    pend_d = pend_d | new_ev | test_ev;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      pend_q      <= '0;
      tone_prev_q <= '0;
    end
    else
    begin
      pend_q      <= pend_d;
      tone_prev_q <= tone_det_i;
    end
  end

  // Event store, oldest entry first.
  ecg_queue u_queue
  (
    .mclk_i       (mclk_i),
    .rstn_i       (rstn_i),
    .push_valid_i (push_valid),
    .push_ready_o (push_ready),
    .push_data_i  (sel_chan),
    .pop_valid_o  (pop_valid),
    .pop_ready_i  (pop_ready),
    .pop_data_o   (pop_data)
  );

  // Receive path: a powered-down group's sample passes through untouched.
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      rout_valid_q <= 1'b0;
      rout_data_q  <= 8'h00;
    end
    else
    begin
      rout_valid_q <= rin_valid_i;
      if (rin_valid_i)
      begin
        rout_data_q <= (gst_q[rin_chan_i[ecg_pkg::CHAN_W-1:1]] == ecg_pkg::ST_DOWN)
                       ? rin_data_i : ec_data_i;
      end
    end
  end

  assign rout_valid_o = rout_valid_q;
  assign rout_data_o  = rout_data_q;

endmodule // ecg_top

`default_nettype wire

// >>> verification/ecg_assertions.sv
// Purpose: Port-level checks for the group control and tone event queue block.
// Assumes: Bound to ecg_top; one clock with a synchronous active-low reset.
// Notes:   Frame edges are counted on the raw pin, so the init check is a lower bound.
`timescale 1ns/1ps
`default_nettype none

module ecg_assertions
(
  input wire logic                        mclk_i,
  input wire logic                        rstn_i,
  input wire logic [ecg_pkg::ADDR_W-1:0]  addr_i,
  input wire logic [ecg_pkg::DATA_W-1:0]  wdata_i,
  input wire logic                        wr_i,
  input wire logic                        rd_i,
  input wire logic [ecg_pkg::DATA_W-1:0]  rdata_o,
  input wire logic                        irq_o,
  input wire logic                        frame_i,
  input wire logic [ecg_pkg::CHANS-1:0]   tone_det_i,
  input wire logic                        rin_valid_i,
  input wire logic [ecg_pkg::CHAN_W-1:0]  rin_chan_i,
  input wire logic [ecg_pkg::DATA_W-1:0]  rin_data_i,
  input wire logic [ecg_pkg::DATA_W-1:0]  ec_data_i,
  input wire logic                        rout_valid_o,
  input wire logic [ecg_pkg::DATA_W-1:0]  rout_data_o,
  input wire logic [ecg_pkg::GROUPS-1:0]  grp_active_o,
  input wire logic [ecg_pkg::GROUPS-1:0]  grp_init_o,
  input wire logic [ecg_pkg::GROUPS-1:0]  grp_g711_o,
  input wire logic [ecg_pkg::GROUPS-1:0]  grp_alaw_o
);
  logic       qrd_q;
  logic       frm_q;
  logic [3:0] frm_cnt_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  // Marks the answer cycle of a queue read, and counts pin rises while group 0 initializes.
  always_ff @(posedge mclk_i)
  begin
    qrd_q <= rstn_i && rd_i && (addr_i == ecg_pkg::QUEUE_ADDR);
    frm_q <= frame_i;
    if (!rstn_i || !grp_init_o[0])
      frm_cnt_q <= 4'h0;
    else if (frame_i && !frm_q && (frm_cnt_q != 4'hF))
      frm_cnt_q <= frm_cnt_q + 4'h1;
  end

  a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read answer");
  a_queue_unused_zero: assert property (qrd_q |-> rdata_o[6:5] == 2'b00)
    else $error("unused queue bits not zero");
  a_queue_empty_zero: assert property (qrd_q && !rdata_o[7] |-> rdata_o == 8'h00)
    else $error("queue read without pending flag carries data");
  a_queue_pend_set: assert property (qrd_q && rdata_o[4:0] != 5'h00 |-> rdata_o[7])
    else $error("queue entry returned without pending flag");
  a_down_bypass: assert property (rin_valid_i && !grp_active_o[rin_chan_i[4:1]]
    && !grp_init_o[rin_chan_i[4:1]] |=> rout_valid_o && rout_data_o == $past(rin_data_i))
    else $error("powered-down group did not pass receive sample");
  a_run_cancel: assert property (rin_valid_i && grp_active_o[rin_chan_i[4:1]]
    |=> rout_valid_o && rout_data_o == $past(ec_data_i))
    else $error("active group did not pass canceller sample");
  a_alaw_needs_fmt: assert property ((grp_alaw_o & ~grp_g711_o) == 16'h0000)
    else $error("law select active without standard code");
  a_fmt_by_write: assert property (!$past(wr_i) |-> $stable(grp_g711_o))
    else $error("code format changed without a write");
  a_init_two_frames: assert property ($rose(grp_active_o[0])
    |-> $past(grp_init_o[0]) && frm_cnt_q >= 4'h2)
    else $error("group became active before two frames of init");
  a_state_excl: assert property ((grp_active_o & grp_init_o) == 16'h0000)
    else $error("group both initializing and active");
endmodule // ecg_assertions

`default_nettype wire

// >>> verification/ecg_host_model.sv
// Purpose: Host processor model that reaches the byte registers of the block.
// Assumes: Strobes are one cycle; read data stand only in the cycle after the strobe.
// Notes:   Each access leaves one idle cycle behind it, which the port tolerates.
`timescale 1ns/1ps
`default_nettype none

module ecg_host_model
(
  input  wire logic                        mclk_i,
  output logic      [ecg_pkg::ADDR_W-1:0]  addr_o,
  output logic      [ecg_pkg::DATA_W-1:0]  wdata_o,
  output logic                             wr_o,
  output logic                             rd_o,
  input  wire logic [ecg_pkg::DATA_W-1:0]  rdata_i
);
  // Idle bus from time zero so the first edge after reset sees no stray strobe.
  initial
  begin
    addr_o  = 11'h000;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // Address, data and write strobe are driven together for exactly one cycle.
  task automatic write_reg(input logic [10:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge mclk_i);
    wr_o    <= 1'b0;
  endtask

  // Data are taken once settled in the answer cycle, before the next edge clears them.
  task automatic read_reg(input logic [10:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge mclk_i);
    rd_o   <= 1'b0;
    #1;
    d = rdata_i;
  endtask
endmodule // ecg_host_model

`default_nettype wire

// >>> verification/ecg_tb_top.sv
// Purpose: Self-checking bench for the group control and tone event queue block.
// Assumes: A host model drives the register port; the bench drives the sample side.
// Notes:   Frames are FR cycles long so a power-up finishes quickly.
`timescale 1ns/1ps
`default_nettype none

module ecg_tb_top;
  localparam int FR = 32;
  typedef struct packed {logic [3:0] g; logic [7:0] d; logic fmt; logic law;} ecg_row_t;
  logic        mclk   = 1'b0;
  logic        rstn   = 1'b0;
  logic        frame  = 1'b0;
  logic [31:0] tone   = 32'h0000_0000;
  logic        rin_v  = 1'b0;
  logic [4:0]  rin_ch = 5'h00;
  logic [7:0]  rin_d  = 8'h00;
  logic [7:0]  ec_d   = 8'h00;
  logic [10:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        irq;
  logic        rout_v;
  logic [7:0]  rout_d;
  logic [15:0] act;
  logic [15:0] ini;
  logic [15:0] g711;
  logic [15:0] alaw;
  logic [7:0]  rv;
  int          fail_count = 0;
  int          n_checks   = 0;
  int          frm_cnt    = 0;
  ecg_row_t    rows [4]   = '{'{4'h1, 8'h04, 1'b1, 1'b0}, '{4'h2, 8'h06, 1'b1, 1'b1},
                             '{4'h3, 8'h02, 1'b0, 1'b0}, '{4'h4, 8'h1C, 1'b1, 1'b0}};

  ecg_host_model host (.mclk_i(mclk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));
  ecg_top dut (.mclk_i(mclk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .frame_i(frame), .tone_det_i(tone),
    .rin_valid_i(rin_v), .rin_chan_i(rin_ch), .rin_data_i(rin_d), .ec_data_i(ec_d),
    .rout_valid_o(rout_v), .rout_data_o(rout_d), .grp_active_o(act), .grp_init_o(ini),
    .grp_g711_o(g711), .grp_alaw_o(alaw));

  // Free-running clock at 125 MHz.
  initial
  begin
    forever #4 mclk = ~mclk;
  end

  // Frame pulses four cycles wide every FR cycles.
  always @(posedge mclk)
  begin
    frm_cnt <= (frm_cnt == FR - 1) ? 0 : frm_cnt + 1;
    frame   <= (frm_cnt < 4);
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // The canceller word is the inverse, so bypass and cancelled paths always differ.
  task automatic rin_cyc(input logic [4:0] ch, input logic [7:0] d, input logic [7:0] exp);
    @(posedge mclk);
    rin_v  <= 1'b1;
    rin_ch <= ch;
    rin_d  <= d;
    ec_d   <= ~d;
    @(posedge mclk);
    rin_v  <= 1'b0;
    #1;
    check("rout", {7'h00, rout_v, rout_d}, {8'h01, exp});
  endtask

  initial
  begin : main
    int n;
    repeat (12) @(posedge mclk);
    check("rst_grp", act | ini | g711 | alaw, 16'h0000);
    rstn <= 1'b1;
    host.read_reg(ecg_pkg::QUEUE_ADDR, rv);
    check("q_empty", rv, 8'h00);
    host.read_reg(11'h7FF, rv);
    check("unmapped", rv, 8'h00);
    $display("test reset done");
    foreach (rows[i])
    begin
      host.write_reg(ecg_pkg::GRP_CTRL_BASE + 11'(rows[i].g), rows[i].d);
      host.read_reg(ecg_pkg::GRP_CTRL_BASE + 11'(rows[i].g), rv);
      check("ctrl_rb", rv, rows[i].d);
      check("g711", g711[rows[i].g], rows[i].fmt);
      check("alaw", alaw[rows[i].g], rows[i].law);
    end
    $display("test rows done");
    rin_cyc(5'h01, 8'h3C, 8'h3C);
    host.write_reg(ecg_pkg::GRP_CTRL_BASE, 8'h05);
    repeat (2) @(posedge mclk);
    #1;
    check("init", ini[0], 1'b1);
    n = 0;
    while (act[0] !== 1'b1 && n < 8 * FR)
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 8 * FR)
    begin
      fail_count++;
      wrap_up();
    end
    check("init_len", (n + 2) >= 2 * FR, 1'b1);
    rin_cyc(5'h00, 8'h5A, 8'hA5);
    $display("test power done");
    // Both channels of group 0 change together; the lower channel must come out first.
    @(posedge mclk);
    tone <= 32'h0000_0003;
    repeat (8) @(posedge mclk);
    host.read_reg(ecg_pkg::QUEUE_ADDR, rv);
    check("queue0", rv, 8'h80);
    host.read_reg(ecg_pkg::QUEUE_ADDR, rv);
    check("queue1", rv, 8'h81);
    host.read_reg(ecg_pkg::QUEUE_ADDR, rv);
    check("queue2", rv, 8'h00);
    @(posedge mclk);
    tone <= 32'h0000_0001;
    repeat (8) @(posedge mclk);
    host.read_reg(ecg_pkg::QUEUE_ADDR, rv);
    check("release", rv, 8'h81);
    $display("test queue done");
    check("irq_masked", irq, 1'b0);
    host.read_reg(ecg_pkg::IRQ_STAT_ADDR, rv);
    check("stat_ev", rv[0], 1'b1);
    host.write_reg(ecg_pkg::IRQ_MASK_ADDR, 8'h01);
    repeat (2) @(posedge mclk);
    #1;
    check("irq_on", irq, 1'b1);
    host.write_reg(ecg_pkg::IRQ_STAT_ADDR, 8'h07);
    repeat (2) @(posedge mclk);
    #1;
    check("irq_clr", irq, 1'b0);
    $display("test irq done");
    host.write_reg(ecg_pkg::TEST_ADDR, 8'h01);
    host.read_reg(ecg_pkg::TEST_ADDR, rv);
    check("test_rb", rv, 8'h01);
    // In test mode clearing both event masks of group 4 queues channels 8 and 9.
    host.write_reg(ecg_pkg::GRP_CTRL_BASE + 11'h004, 8'h04);
    host.read_reg(ecg_pkg::QUEUE_ADDR, rv);
    check("test_ev0", rv, 8'h88);
    host.read_reg(ecg_pkg::QUEUE_ADDR, rv);
    check("test_ev1", rv, 8'h89);
    check("irq_test", irq, 1'b1);
    host.write_reg(ecg_pkg::TEST_ADDR, 8'h00);
    // A masked channel of a running group must not queue anything.
    host.write_reg(ecg_pkg::GRP_CTRL_BASE, 8'h0D);
    @(posedge mclk);
    tone <= 32'h0000_0000;
    repeat (8) @(posedge mclk);
    host.read_reg(ecg_pkg::QUEUE_ADDR, rv);
    check("masked", rv, 8'h00);
    $display("test mode done");
    host.write_reg(ecg_pkg::GRP_CTRL_BASE, 8'h04);
    repeat (2) @(posedge mclk);
    #1;
    check("down", act[0], 1'b0);
    rin_cyc(5'h00, 8'h77, 8'h77);
    $display("test power down done");
    wrap_up();
  end
endmodule // ecg_tb_top

bind ecg_top ecg_assertions u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .frame_i(frame_i), .tone_det_i(tone_det_i), .rin_valid_i(rin_valid_i),
  .rin_chan_i(rin_chan_i), .rin_data_i(rin_data_i), .ec_data_i(ec_data_i),
  .rout_valid_o(rout_valid_o), .rout_data_o(rout_data_o), .grp_active_o(grp_active_o),
  .grp_init_o(grp_init_o), .grp_g711_o(grp_g711_o), .grp_alaw_o(grp_alaw_o));

`default_nettype wire
